// *** rtp_defs.svh ***
// Constants for the radio transmit request parser
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH
`define RTP_SYNC_BYTE       8'h55
`define RTP_PT_LEGACY       8'h01
`define RTP_PT_RAW          8'h0a
`define RTP_PT_CHAINED      8'h09
`define RTP_PT_RESPONSE     8'h02
`define RTP_PT_EVENT        8'h04
`define RTP_OPT_LEGACY      8'h07
`define RTP_OPT_RAW         8'h03
`define RTP_OPT_CHAINED     8'h0a
`define RTP_RET_SUCCESS     8'h00
`define RTP_RET_UNSUPPORTED 8'h02
`define RTP_RET_BAD_PARAM   8'h03
`define RTP_RET_LOCKED      8'h05
`define RTP_EVT_TX_DONE     8'h08
`define RTP_SUBTEL_COUNT    8'h03
`define RTP_DBM_UNUSED      8'hff
`define RTP_SOURCE_ZERO     32'h00000000
`define RTP_BROADCAST_ID    32'hffffffff
`define RTP_LEGACY_MAX_BC   16'h000e
`define RTP_LEGACY_MAX_ADT  16'h0009
`define RTP_SEG_STD         16'h000e
`define RTP_SEG_EXT         16'h0022
`define RTP_HDR_CRC_OFS     5
`define RTP_DATA_OFS        6
`define RTP_SHUTDOWN_MS     40
`define RTP_CLK_MHZ         50
`define RTP_SUBTEL_CYC      32'd16
`define RTP_MAX_FRAME       64
`endif

// *** rtp_pkg.sv ***
// Types shared by both ends of the transmit request link
package rtp_pkg;
  typedef logic [7:0] rtp_byte_t;
  typedef enum logic [6:0] {
    RTP_HUNT = 7'b0000001,
    RTP_HDR  = 7'b0000010,
    RTP_BODY = 7'b0000100,
    RTP_RESP = 7'b0001000,
    RTP_SEND = 7'b0010000,
    RTP_EVT  = 7'b0100000,
    RTP_IDLE = 7'b1000000
  } rtp_state_t;

  // CRC8 step, polynomial x8+x2+x+1, shared by both ends
  function automatic rtp_byte_t rtp_crc8(input rtp_byte_t crc,
                                         input rtp_byte_t data);
    rtp_byte_t c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction : rtp_crc8
endpackage : rtp_pkg

// *** rtp_link_if.sv ***
// Byte stream link between host and gateway device
`timescale 1ns/100ps
interface rtp_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;
  modport device (input h2d_data, input h2d_valid, output h2d_ready,
                  output d2h_data, output d2h_valid, input d2h_ready);
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
                input d2h_data, input d2h_valid, output d2h_ready);
endinterface : rtp_link_if

// *** rtp_device.sv ***
// Gateway end: parses transmit requests, answers, signals completion
//
// How it works
// - Legacy request: type 01, optional length 07
// - Header checksum at byte offset five
// - Last byte checksums data plus optional data
// - Host puts subtelegram count 3 first
// - All-ones destination broadcasts, else addressed
// - Legacy security byte ignored, link table used
// - Legacy payload max 14 broadcast, 9 addressed
// - Too long legacy payload answers bad parameter
// - Good request without lock answers success
// - Airtime lock active answers locked code 05
// - Transmission end sends complete event 08
// - Host waits 40 ms or complete event
// - Raw request: type 0A, optional length 03
// - Variant without raw protocol answers unsupported
// - Raw data lacks length byte, checksum arbitrary
// - Host sets count 03, strength FF
// - Raw payload segmented at 14 or 34
// - Chained request: type 09, optional length 0A
// - Chained data starts with message type byte
// - Host sends destination, zero source, FF, security
// - Chained payloads beyond limit sent by chaining
// - Chained request under lock answers locked
`timescale 1ns/100ps
`include "rtp_defs.svh"
module rtp_device
  import rtp_pkg::*;
#(
  parameter bit RAW_SUPPORTED = 1'b1,
  parameter bit EXTENDED      = 1'b0
)(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  rtp_link_if.device      link,
  input  wire logic       i_airtime_lock,
  output logic            o_tx_busy,
  output logic            o_seg_start,
  output logic      [7:0] o_tx_dest_bcast,
  output logic      [7:0] o_telegram_crc,
  output logic            o_frame_dropped
);
  rtp_state_t       state, next_state;
  logic      [15:0] cnt, next_cnt;
  logic      [15:0] dlen, next_dlen;
  logic       [7:0] olen, next_olen;
  logic       [7:0] ptype, next_ptype;
  logic       [7:0] crc, next_crc;
  logic       [7:0] tcrc, next_tcrc;
  logic      [31:0] dest, next_dest;
  logic       [7:0] resp, next_resp;
  logic       [2:0] ocnt, next_ocnt;
  logic      [31:0] tx_cyc, next_tx_cyc;
  logic      [15:0] seg_cnt, next_seg_cnt;
  logic             drop, next_drop;
  logic             seg, next_seg;
  logic             is_bc;
  logic      [15:0] seg_lim;
  logic      [15:0] dend;
  logic      [7:0]  obyte;
  logic      [7:0]  ans_type;
  logic             fire;

  assign fire    = link.h2d_valid & link.h2d_ready;
  assign dend    = dlen + {8'h00, olen};
  assign is_bc   = (dest == `RTP_BROADCAST_ID);
  assign seg_lim = EXTENDED ? `RTP_SEG_EXT : `RTP_SEG_STD;
  assign ans_type = (state == RTP_EVT) ? `RTP_PT_EVENT : `RTP_PT_RESPONSE;
  assign link.h2d_ready = (state == RTP_HUNT) || (state == RTP_HDR) ||
                          (state == RTP_BODY);

  // Outgoing byte selection for response and event frames
  always_comb
  begin
    unique case (ocnt)
      3'd0: obyte = `RTP_SYNC_BYTE;
      3'd1: obyte = 8'h00;
      3'd2: obyte = 8'h01;
      3'd3: obyte = 8'h00;
      3'd4: obyte = ans_type;
      3'd5: obyte = rtp_crc8(rtp_crc8(rtp_crc8(rtp_crc8(8'h00, 8'h00),
                    8'h01), 8'h00), ans_type);
      3'd6: obyte = resp;
      3'd7: obyte = rtp_crc8(8'h00, resp);
    endcase
  end

  // Parser, answer and transmit sequencing
  always_comb
  begin
    next_state  = state;
    next_tx_cyc = tx_cyc;
    {next_cnt, next_dlen, next_seg_cnt} = {cnt, dlen, seg_cnt};
    {next_olen, next_ptype, next_crc, next_tcrc} = {olen, ptype, crc, tcrc};
    {next_dest, next_resp, next_ocnt} = {dest, resp, ocnt};
    {next_drop, next_seg} = 2'b00;
    unique case (state)
      RTP_HUNT:
      begin
        if (fire && link.h2d_data == `RTP_SYNC_BYTE)
        begin
          next_state = RTP_HDR;
          next_cnt   = 16'd1;
          next_crc   = 8'h00;
        end
      end
      RTP_HDR:
      begin
        if (fire)
        begin
          next_cnt = cnt + 16'd1;
          next_crc = rtp_crc8(crc, link.h2d_data);
          if (cnt == 16'd1)
            next_dlen[15:8] = link.h2d_data;
          if (cnt == 16'd2)
            next_dlen[7:0] = link.h2d_data;
          if (cnt == 16'd3)
            next_olen = link.h2d_data;
          if (cnt == 16'd4)
            next_ptype = link.h2d_data;
          if (cnt == `RTP_HDR_CRC_OFS)
          begin
            next_crc  = 8'h00;
            next_tcrc = 8'h00;
            next_dest = 32'h0;
            next_cnt  = 16'd0;
            if (link.h2d_data != crc)
            begin
              next_state = RTP_HUNT;
              next_drop  = 1'b1;
            end
            else
              next_state = RTP_BODY;
          end
        end
      end
      RTP_BODY:
      begin
        if (fire)
        begin
          next_cnt = cnt + 16'd1;
          next_crc = rtp_crc8(crc, link.h2d_data);
          // Raw telegram checksum built locally
          if (cnt < dlen && !(ptype == `RTP_PT_RAW && cnt == dlen - 16'd1))
            next_tcrc = rtp_crc8(tcrc, link.h2d_data);
          // Destination after count, or right after the data if chained; security unused
          if (cnt + {15'h0000, ptype == `RTP_PT_CHAINED} >= dlen + 16'd1 &&
              cnt + {15'h0000, ptype == `RTP_PT_CHAINED} <= dlen + 16'd4 &&
              ptype != `RTP_PT_RAW)
            next_dest = {dest[23:0], link.h2d_data};
          if (cnt == dend)
          begin
            next_ocnt = 3'd0;
            if (link.h2d_data != crc)
            begin
              next_state = RTP_HUNT;
              next_drop  = 1'b1;
            end
            else
            begin
              next_state = RTP_RESP;
              if (ptype == `RTP_PT_LEGACY && olen == `RTP_OPT_LEGACY)
              begin
                if (dlen > (is_bc ? `RTP_LEGACY_MAX_BC :
                            `RTP_LEGACY_MAX_ADT))
                  next_resp = `RTP_RET_BAD_PARAM;
                else if (i_airtime_lock)
                  next_resp = `RTP_RET_LOCKED;
                else
                  next_resp = `RTP_RET_SUCCESS;
              end
              else if (ptype == `RTP_PT_RAW && olen == `RTP_OPT_RAW)
              begin
                if (!RAW_SUPPORTED)
                  next_resp = `RTP_RET_UNSUPPORTED;
                else if (i_airtime_lock)
                  next_resp = `RTP_RET_LOCKED;
                else
                  next_resp = `RTP_RET_SUCCESS;
              end
              else if (ptype == `RTP_PT_CHAINED &&
                       olen == `RTP_OPT_CHAINED && dlen != 16'd0)
              begin
                if (i_airtime_lock)
                  next_resp = `RTP_RET_LOCKED;
                else
                  next_resp = `RTP_RET_SUCCESS;
              end
              else
                next_resp = `RTP_RET_BAD_PARAM;
            end
          end
        end
      end
      RTP_RESP:
      begin
        if (link.d2h_ready)
        begin
          next_ocnt = ocnt + 3'd1;
          if (ocnt == 3'd7)
          begin
            next_seg_cnt = dlen;
            next_tx_cyc  = `RTP_SUBTEL_CYC;
            next_state   = (resp == `RTP_RET_SUCCESS) ? RTP_SEND : RTP_HUNT;
            next_seg     = (resp == `RTP_RET_SUCCESS);
          end
        end
      end
      RTP_SEND:
      begin
        // One segment per subtelegram slot, chained if oversize
        if (tx_cyc != 32'd0)
          next_tx_cyc = tx_cyc - 32'd1;
        else if (seg_cnt > seg_lim)
        begin
          next_seg_cnt = seg_cnt - seg_lim;
          next_tx_cyc  = `RTP_SUBTEL_CYC;
          next_seg     = 1'b1;
        end
        else
        begin
          next_state = RTP_EVT;
          next_resp  = `RTP_EVT_TX_DONE;
          next_ocnt  = 3'd0;
        end
      end
      RTP_EVT:
      begin
        if (link.d2h_ready)
        begin
          next_ocnt = ocnt + 3'd1;
          if (ocnt == 3'd7)
            next_state = RTP_HUNT;
        end
      end
      default:
        next_state = RTP_HUNT;
    endcase
  end

  // Register stage
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      state <= RTP_HUNT;
      {cnt, dlen, seg_cnt} <= 48'h0;
      {olen, ptype, crc, tcrc, resp} <= 40'h0;
      {dest, tx_cyc} <= 64'h0;
      {ocnt, drop, seg} <= 5'h0;
    end
    else
    begin
      state <= next_state;
      {cnt, dlen, seg_cnt} <= {next_cnt, next_dlen, next_seg_cnt};
      {olen, ptype, crc} <= {next_olen, next_ptype, next_crc};
      {tcrc, resp, ocnt} <= {next_tcrc, next_resp, next_ocnt};
      {dest, tx_cyc} <= {next_dest, next_tx_cyc};
      {drop, seg} <= {next_drop, next_seg};
    end
  end

  assign link.d2h_valid  = (state == RTP_RESP) || (state == RTP_EVT);
  assign link.d2h_data   = obyte;
  assign o_tx_busy       = (state == RTP_SEND);
  assign o_seg_start     = seg;
  assign o_tx_dest_bcast = {7'h00, is_bc};
  assign o_telegram_crc  = tcrc;
  assign o_frame_dropped = drop;
endmodule : rtp_device

// *** rtp_host.sv ***
// Host end: frames transmit requests and collects answers
`timescale 1ns/100ps
`include "rtp_defs.svh"
module rtp_host
  import rtp_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  rtp_link_if.host        link,
  input  wire logic       i_req,
  input  wire logic [7:0] i_ptype,
  input  wire logic [5:0] i_len,
  input  wire logic [7:0] i_byte_wdata,
  input  wire logic [5:0] i_byte_addr,
  input  wire logic       i_byte_we,
  input  wire logic [31:0] i_dest,
  output logic            o_busy,
  output logic            o_resp_valid,
  output logic      [7:0] o_resp_code,
  output logic            o_tx_done,
  output logic            o_shutdown_ok
);
  localparam int unsigned HOLD_CYC = `RTP_SHUTDOWN_MS * 1000 * `RTP_CLK_MHZ;
  logic       [7:0] mem [`RTP_MAX_FRAME];
  logic       [5:0] len;
  logic       [7:0] ptype;
  logic      [31:0] dest;
  logic       [5:0] idx, next_idx;
  logic       [7:0] crc, next_crc;
  logic             busy, next_busy;
  logic       [2:0] rcnt, next_rcnt;
  logic       [7:0] rtype, next_rtype;
  logic       [7:0] code, next_code;
  logic             rv, next_rv;
  logic             td, next_td;
  logic      [21:0] hold, next_hold;
  logic       [4:0] pos;
  logic       [7:0] olen;
  logic      [15:0] dl;
  logic       [7:0] txb;
  logic       [5:0] last;

  // Optional length and trailer per packet kind
  assign olen = (ptype == `RTP_PT_LEGACY) ? `RTP_OPT_LEGACY :
                (ptype == `RTP_PT_RAW)    ? `RTP_OPT_RAW : `RTP_OPT_CHAINED;
  assign dl   = {10'h000, len};
  assign last = 6'(6 + len) + 6'(olen);

  // Byte to send at index idx
  always_comb
  begin
    pos = 5'(idx - 6'(6) - len);
    txb = 8'h00;
    if (idx == 6'd0)
      txb = `RTP_SYNC_BYTE;
    else if (idx == 6'd1)
      txb = dl[15:8];
    else if (idx == 6'd2)
      txb = dl[7:0];
    else if (idx == 6'd3)
      txb = olen;
    else if (idx == 6'd4)
      txb = ptype;
    else if (idx == 6'(`RTP_HDR_CRC_OFS) || idx == last)
      txb = crc;
    else if (idx < 6'(6) + len)
      txb = mem[idx - 6'(6)];
    else if (ptype == `RTP_PT_CHAINED)
      // Destination, zero source, strength, security
      unique case (pos)
        5'd0: txb = dest[31:24];
        5'd1: txb = dest[23:16];
        5'd2: txb = dest[15:8];
        5'd3: txb = dest[7:0];
        5'd8: txb = `RTP_DBM_UNUSED;
        default: txb = 8'h00;
      endcase
    else
      // Count 3, destination or strength, then security
      unique case (pos)
        5'd0: txb = `RTP_SUBTEL_COUNT;
        5'd1: txb = (ptype == `RTP_PT_RAW) ? `RTP_DBM_UNUSED : dest[31:24];
        5'd2: txb = (ptype == `RTP_PT_RAW) ? 8'h00 : dest[23:16];
        5'd3: txb = dest[15:8];
        5'd4: txb = dest[7:0];
        5'd5: txb = `RTP_DBM_UNUSED;
        default: txb = 8'h00;
      endcase
  end

  // Payload store and request capture
  always_ff @(posedge i_sys_clk)
  begin
    if (i_byte_we && !busy)
      mem[i_byte_addr] <= i_byte_wdata;
    if (!i_nrst)
    begin
      len   <= 6'd0;
      ptype <= `RTP_PT_LEGACY;
      dest  <= 32'h0;
    end
    else if (i_req && !busy)
    begin
      len   <= i_len;
      ptype <= i_ptype;
      dest  <= i_dest;
    end
  end

  // Sender, answer collector and shutdown timer
  always_comb
  begin
    next_idx   = idx;
    next_crc   = crc;
    next_busy  = busy;
    next_rcnt  = rcnt;
    next_rtype = rtype;
    next_code  = code;
    next_rv    = 1'b0;
    next_td    = 1'b0;
    next_hold  = (hold != 22'd0) ? hold - 22'd1 : hold;
    if (i_req && !busy)
    begin
      next_busy = 1'b1;
      next_idx  = 6'd0;
      next_crc  = 8'h00;
    end
    else if (busy && link.h2d_ready)
    begin
      next_idx = idx + 6'd1;
      if (idx == 6'(`RTP_HDR_CRC_OFS))
        next_crc = 8'h00;
      else if (idx != 6'd0)
        next_crc = rtp_crc8(crc, txb);
      if (idx == last)
        next_busy = 1'b0;
    end
    if (link.d2h_valid)
    begin
      next_rcnt = rcnt + 3'd1;
      if (rcnt == 3'd4)
        next_rtype = link.d2h_data;
      if (rcnt == 3'd6)
      begin
        next_code = link.d2h_data;
        if (rtype == `RTP_PT_EVENT)
        begin
          next_td   = 1'b1;
          next_hold = 22'd0;
        end
        else
        begin
          next_rv = 1'b1;
          if (link.d2h_data == `RTP_RET_SUCCESS)
            next_hold = 22'(HOLD_CYC);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      idx   <= 6'd0;
      crc   <= 8'h00;
      busy  <= 1'b0;
      rcnt  <= 3'd0;
      rtype <= 8'h00;
      code  <= 8'h00;
      rv    <= 1'b0;
      td    <= 1'b0;
      hold  <= 22'd0;
    end
    else
    begin
      idx   <= next_idx;
      crc   <= next_crc;
      busy  <= next_busy;
      rcnt  <= next_rcnt;
      rtype <= next_rtype;
      code  <= next_code;
      rv    <= next_rv;
      td    <= next_td;
      hold  <= next_hold;
    end
  end

  assign link.h2d_valid = busy;
  assign link.h2d_data  = txb;
  assign link.d2h_ready = 1'b1;
  assign o_busy         = busy;
  assign o_resp_valid   = rv;
  assign o_resp_code    = code;
  assign o_tx_done      = td;
  assign o_shutdown_ok  = (hold == 22'd0);
endmodule : rtp_host

// *** rtp_link_monitor.sv ***
// Checker for the host to gateway byte link
`timescale 1ns/100ps
module rtp_link_monitor (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  logic [7:0] hi, len, olen, ptype, crc, di, dtype;
  logic       hx, dx, last;
  default clocking cb_mon @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  // Accepted bytes and final byte of a request frame
  assign hx = h2d_valid & h2d_ready;
  assign dx = d2h_valid & d2h_ready;
  assign last = (hi == 8'd6 + len + olen);

  // Checksum step, polynomial 07
  function automatic logic [7:0] c8(input logic [7:0] c,
                                    input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction : c8

  // Frame positions, stored header fields, running checksum
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      hi <= 8'h00;
      di <= 8'h00;
      {len, olen, ptype} <= 24'h0;
      {crc, dtype} <= 16'h0;
    end
    else
    begin
      if (hx)
      begin
        hi  <= last ? 8'h00 : hi + 8'h01;
        crc <= (hi == 8'd0 || hi == 8'd5) ? 8'h00 : c8(crc, h2d_data);
      end
      if (hx && hi == 8'd2) len <= h2d_data;
      if (hx && hi == 8'd3) olen <= h2d_data;
      if (hx && hi == 8'd4) ptype <= h2d_data;
      if (dx) di <= (di == 8'd7) ? 8'h00 : di + 8'h01;
      if (dx && di == 8'd4) dtype <= d2h_data;
    end
  end

  property p_legacy_olen;
    hx && hi == 8'd4 && h2d_data == 8'h01 |-> olen == 8'h07;
  endproperty
  a_legacy_olen: assert property (p_legacy_olen)
    else $error("legacy optional length wrong");
  property p_raw_olen;
    hx && hi == 8'd4 && h2d_data == 8'h0a |-> olen == 8'h03;
  endproperty
  a_raw_olen: assert property (p_raw_olen)
    else $error("raw optional length wrong");
  property p_chain_olen;
    hx && hi == 8'd4 && h2d_data == 8'h09 |-> olen == 8'h0a;
  endproperty
  a_chain_olen: assert property (p_chain_olen)
    else $error("chained optional length wrong");
  property p_hdr_crc;
    hx && hi == 8'd5 |-> h2d_data == crc;
  endproperty
  a_hdr_crc: assert property (p_hdr_crc)
    else $error("header checksum wrong");
  property p_data_crc;
    hx && hi > 8'd5 && last |-> h2d_data == crc;
  endproperty
  a_data_crc: assert property (p_data_crc)
    else $error("data checksum wrong");
  property p_count;
    hx && hi > 8'd5 && hi == 8'd6 + len
      && (ptype == 8'h01 || ptype == 8'h0a) |-> h2d_data == 8'h03;
  endproperty
  a_count: assert property (p_count)
    else $error("subtelegram count wrong");
  property p_source_zero;
    hx && ptype == 8'h09 && hi >= 8'd10 + len && hi <= 8'd13 + len
      |-> h2d_data == 8'h00;
  endproperty
  a_source_zero: assert property (p_source_zero)
    else $error("source id not zero");
  property p_raw_strength;
    hx && ptype == 8'h0a && hi == 8'd7 + len |-> h2d_data == 8'hff;
  endproperty
  a_raw_strength: assert property (p_raw_strength)
    else $error("raw signal strength wrong");
  property p_answer;
    hx && hi > 8'd5 && last |=> d2h_valid && d2h_data == 8'h55;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer not started at once");
  property p_evt_code;
    dx && di == 8'd6 && dtype == 8'h04 |-> d2h_data == 8'h08;
  endproperty
  a_evt_code: assert property (p_evt_code)
    else $error("event code wrong");

  // Main traffic kinds
  c_legacy: cover property (hx && hi == 8'd4 && h2d_data == 8'h01);
  c_event: cover property (dx && di == 8'd6 && dtype == 8'h04);
  c_locked: cover property (dx && di == 8'd6 && d2h_data == 8'h05);
endmodule : rtp_link_monitor

// *** test_radio_tx_request_parser.sv ***
// Bench joining host and gateway ends, plus a hand-driven gateway
`timescale 1ns/100ps
module test_radio_tx_request_parser;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_req = 1'b0;
  logic [7:0]  i_ptype = 8'h00;
  logic [5:0]  i_len = 6'h00;
  logic [7:0]  i_byte_wdata = 8'h00;
  logic [5:0]  i_byte_addr = 6'h00;
  logic        i_byte_we = 1'b0;
  logic [31:0] i_dest = 32'h0;
  logic        i_airtime_lock = 1'b0;
  logic        o_busy, o_resp_valid, o_tx_done, o_shutdown_ok;
  logic        seg_start, drop2, tx_busy;
  logic [7:0]  o_resp_code, bcast, tcrc;
  logic [31:0] seed = 32'h48fd;
  logic [31:0] dst;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0;
  int          checked = 0;
  int          nseg = 0;
  int          ndrop = 0;
  rtp_link_if lk ();
  rtp_link_if lk2 ();

  // System clock, 20 ns period
  initial forever #10 i_sys_clk = ~i_sys_clk;

  rtp_host rtp_host_inst (.i_sys_clk, .i_nrst, .link(lk.host), .i_req,
    .i_ptype, .i_len, .i_byte_wdata, .i_byte_addr, .i_byte_we, .i_dest,
    .o_busy, .o_resp_valid, .o_resp_code, .o_tx_done, .o_shutdown_ok);
  rtp_device rtp_device_inst (.i_sys_clk, .i_nrst, .link(lk.device),
    .i_airtime_lock, .o_tx_busy(tx_busy), .o_seg_start(seg_start),
    .o_tx_dest_bcast(bcast), .o_telegram_crc(tcrc), .o_frame_dropped());
  rtp_device #(.RAW_SUPPORTED(1'b0), .EXTENDED(1'b1)) rtp_device_inst_2 (
    .i_sys_clk, .i_nrst, .link(lk2.device), .i_airtime_lock(1'b0),
    .o_tx_busy(), .o_seg_start(), .o_tx_dest_bcast(),
    .o_telegram_crc(), .o_frame_dropped(drop2));
  rtp_link_monitor rtp_link_monitor_inst (.i_sys_clk, .i_nrst,
    .h2d_data(lk.h2d_data), .h2d_valid(lk.h2d_valid),
    .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
    .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));

  // Xorshift source
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Checksum step, polynomial 07
  function automatic logic [7:0] c8(input logic [7:0] c,
                                    input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction : c8

  task automatic step;
    @(posedge i_sys_clk);
    #1;
  endtask : step

  task automatic results;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic fail(input string nm);
    n_mismatch++;
    $display("[FAIL] %s expected done seen timeout", nm);
    results();
  endtask : fail

  // Watches answers, segment pulses and drops
  always @(posedge i_sys_clk)
  begin
    if (seg_start === 1'b1) nseg++;
    if (drop2 === 1'b1) ndrop++;
    if (o_resp_valid === 1'b1)
    begin
      if (exp_q.size() == 0) fail("unexpected answer");
      cmp("resp_code", exp_q.pop_front(), o_resp_code);
    end
  end

  // One request through the host end, expected code noted first
  task automatic send(input logic [7:0] pt, input logic [5:0] n,
                      input logic [31:0] d, input logic lock,
                      input logic [7:0] e, input int sg);
    int t;
    logic [7:0] tc;
    logic [7:0] b;
    tc = 8'h00;
    for (t = 0; t < 9000 && o_busy !== 1'b0; t++) step();
    for (t = 0; t < n; t++)
    begin
      i_byte_we = 1'b1;
      i_byte_addr = t[5:0];
      b = rnd();
      i_byte_wdata = b;
      if (t < n - 1) tc = c8(tc, b);
      step();
    end
    i_byte_we = 1'b0;
    {i_ptype, i_len, i_dest, i_airtime_lock} = {pt, n, d, lock};
    nseg = 0;
    exp_q.push_back(e);
    i_req = 1'b1;
    step();
    i_req = 1'b0;
    for (t = 0; t < 3000 && exp_q.size() != 0; t++) step();
    if (t == 3000) fail("answer");
    if (pt == 8'h0a) cmp("telegram_crc", tc, tcrc);
    if (e == 8'h00)
    begin
      cmp("shutdown_ok", 8'h00, {7'h0, o_shutdown_ok});
      cmp("tx_busy", 8'h01, {7'h0, tx_busy});
      if (pt != 8'h0a)
        cmp("bcast", {7'h0, d == '1}, {7'h0, bcast[0]});
      for (t = 0; t < 3000 && o_tx_done !== 1'b1; t++) step();
      if (t == 3000) fail("tx_done");
      step();
      cmp("shutdown_ok", 8'h01, {7'h0, o_shutdown_ok});
      cmp("tx_busy", 8'h00, {7'h0, tx_busy});
      if (sg != 0) cmp("segments", sg[7:0], nseg[7:0]);
    end
  endtask : send

  // Raw frame straight onto the second link, data checksum xor bad
  task automatic frame2(input logic [7:0] bad);
    logic [7:0] f[$];
    int t;
    f = '{8'h55, 8'h00, 8'h04, 8'h03, 8'h0a, 8'h00};
    for (t = 1; t < 5; t++) f[5] = c8(f[5], f[t]);
    f = {f, rnd(), rnd(), rnd(), rnd(), 8'h03, 8'hff, 8'h00, 8'h00};
    for (t = 6; t < 13; t++) f[13] = c8(f[13], f[t]);
    f[13] = f[13] ^ bad;
    ndrop = 0;
    foreach (f[k])
    begin
      lk2.h2d_data = f[k];
      lk2.h2d_valid = 1'b1;
      for (t = 0; t < 50; t++)
      begin
        @(posedge i_sys_clk);
        if (lk2.h2d_ready === 1'b1) break;
      end
      #1;
      if (t == 50) fail("link stall");
    end
    lk2.h2d_valid = 1'b0;
    f = {};
    for (t = 0; t < 40; t++)
    begin
      @(posedge i_sys_clk);
      if (lk2.d2h_valid === 1'b1) f.push_back(lk2.d2h_data);
    end
    #1;
    cmp("dropped", {7'h0, bad != 8'h00}, ndrop[7:0]);
    cmp("answer_len", bad != 8'h00 ? 8'd0 : 8'd8, 8'(f.size()));
    if (bad == 8'h00)
    begin
      cmp("answer_code", 8'h02, f[6]);
      cmp("answer_crc", c8(8'h00, 8'h02), f[7]);
    end
  endtask : frame2

  // Main sequence
  initial
  begin
    lk2.h2d_data = 8'h00;
    lk2.h2d_valid = 1'b0;
    lk2.d2h_ready = 1'b1;
    dst = {rnd() & 8'h7f, rnd(), rnd(), rnd()};
    repeat (12) step();
    i_nrst = 1'b1;
    send(8'h01, 6'd14, '1, 1'b0, 8'h00, 1);
    send(8'h01, 6'd15, '1, 1'b0, 8'h03, 0);
    send(8'h01, 6'd9, dst, 1'b0, 8'h00, 1);
    send(8'h01, 6'd10, dst, 1'b0, 8'h03, 0);
    send(8'h0a, 6'd20, 32'h0, 1'b0, 8'h00, 2);
    send(8'h0a, 6'd14, 32'h0, 1'b0, 8'h00, 1);
    send(8'h09, 6'd40, '1, 1'b0, 8'h00, 3);
    send(8'h01, 6'd5, '1, 1'b1, 8'h05, 0);
    send(8'h09, 6'd5, dst, 1'b1, 8'h05, 0);
    repeat (4) send(8'h01, 6'(rnd() % 14 + 1), '1, 1'b0, 8'h00, 1);
    frame2(8'h00);
    frame2(8'h01);
    results();
  end
endmodule : test_radio_tx_request_parser
